/* common/vop_params.svh */
`ifndef VOP_PARAMS_SVH
`define VOP_PARAMS_SVH

// Byte offsets inside the 32-byte board window
`define VOP_OFS_DATA0     5'h00
`define VOP_OFS_DATA1     5'h04
`define VOP_OFS_DATA2     5'h08
`define VOP_OFS_DATA3     5'h0c
`define VOP_OFS_CSR       5'h10

// Control/status register fields
`define VOP_CSR_TEST_LSB  0
`define VOP_CSR_TEST_MSB  1
`define VOP_CSR_FAULT_BIT 2
`define VOP_CSR_TEST_ON   2'h3
`define VOP_CSR_RESET     3'h4

// Address space limits
`define VOP_WIN_LSB       5
`define VOP_SHORT_TOP     15
`define VOP_STD_TOP       23
`define VOP_BASE_W        19
`define VOP_SHORT_BASE_W  11

`endif

/* common/vop_pkg.sv */
package vop_pkg;

    typedef struct packed {
        logic       fault;
        logic [1:0] test;
    } vop_csr_t;

    typedef struct packed {
        logic        claim;
        logic        csr_sel;
        logic        data_sel;
        logic [1:0]  lw;
    } vop_decode_t;

endpackage

/* dv/vop_host_model.sv */
module vop_host_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [31:0]      paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb,
    output logic [2:0]       pprot,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    int waits;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        pprot = 3'h0;
    end
    task automatic xfer(input logic w, input logic [31:0] a, d,
                        input logic [3:0] s, input logic [2:0] p,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        pprot <= p;
        @(posedge pclk);
        penable <= 1'b1;
        waits = 0;
        do begin
            @(posedge pclk);
            waits++;
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule

/* dv/vop_output_port_tb.sv */
module vop_output_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         pclk = 1'b0;
    logic         presetn;
    logic         psel, penable, pwrite, pready, pslverr, serr;
    logic         fault_indicator;
    logic [31:0]  paddr, pwdata, prdata, rdat;
    logic [3:0]   pstrb;
    logic [2:0]   pprot;
    logic [127:0] chan_sink;
    logic [18:0]  base_jumper = 19'h00000;
    int           mismatches, check_count;
    logic [31:0]  pats [4] = '{32'h8001_0001, 32'h0204_a5f0,
                               32'h5a5a_c3c3, 32'hffff_0000};
    logic [31:0]  bad_a [5] = '{32'h0, 32'h20, 32'h1_0000, 32'h14, 32'h2};
    logic [2:0]   bad_p [5] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h1};

    always #5 pclk = ~pclk;

    vop_host_model u_vop_host_model (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    vop_output_port u_vop_output_port (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .base_jumper(base_jumper),
        .chan_sink(chan_sink), .fault_indicator(fault_indicator));

    task automatic check(input string nm, input logic [127:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic acc(input logic w, input logic [31:0] a, d,
                       input logic [3:0] s, input logic [2:0] p);
        u_vop_host_model.xfer(w, a, d, s, p, rdat, serr);
    endtask

    task automatic settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic t_longwords;
        for (int k = 0; k < 4; k++) acc(1'b1, 32'(4*k), pats[k], 4'hf, 3'h1);
        check("lat", 128'(u_vop_host_model.waits), 128'h2);
        for (int k = 0; k < 4; k++) begin
            acc(1'b0, 32'(4*k), 32'h0, 4'hf, 3'h1);
            check("lw", rdat, pats[k]);
        end
        settle;
        check("drv", chan_sink, {pats[3], pats[2], pats[1], pats[0]});
    endtask

    task automatic t_lanes;
        acc(1'b1, 32'h0, 32'h00ab_0000, 4'h4, 3'h1);
        acc(1'b1, 32'h4, 32'h0000_cafe, 4'h3, 3'h1);
        acc(1'b0, 32'h0, 32'h0, 4'hf, 3'h1);
        check("byte", rdat, 32'h80ab_0001);
        acc(1'b0, 32'h4, 32'h0, 4'hf, 3'h1);
        check("word", rdat, 32'h0204_cafe);
    endtask

    task automatic t_selftest;
        acc(1'b1, 32'h10, 32'h1, 4'h1, 3'h1);
        settle;
        check("half", chan_sink[31:0], 32'h80ab_0001);
        acc(1'b1, 32'h10, 32'h7, 4'h1, 3'h1);
        acc(1'b1, 32'h8, 32'h1234_5678, 4'hf, 3'h1);
        settle;
        check("off", chan_sink, 128'h0);
        check("lamp", fault_indicator, 1'b1);
        acc(1'b0, 32'h8, 32'h0, 4'hf, 3'h1);
        check("bit", rdat, 32'h1234_5678);
        acc(1'b0, 32'h10, 32'h0, 4'hf, 3'h1);
        check("csr", rdat, 32'h7);
        acc(1'b1, 32'h10, 32'h0, 4'h1, 3'h1);
        settle;
        check("on", chan_sink[95:64], 32'h1234_5678);
        check("dark", fault_indicator, 1'b0);
    endtask

    task automatic t_refuse;
        for (int k = 0; k < 5; k++) begin
            acc(1'b1, bad_a[k], 32'hffff_ffff, 4'hf, bad_p[k]);
            check("err", serr, 1'b1);
            acc(1'b0, bad_a[k], 32'h0, 4'hf, bad_p[k]);
            check("rd0", rdat, 32'h0);
        end
        acc(1'b0, 32'h0, 32'h0, 4'hf, 3'h1);
        check("kept", rdat, 32'h80ab_0001);
        check("ok", serr, 1'b0);
    endtask

    task automatic t_base;
        base_jumper <= 19'h00002;
        acc(1'b1, 32'h48, 32'h0f0f_a5a5, 4'hf, 3'h1);
        check("moved", serr, 1'b0);
        acc(1'b0, 32'h8, 32'h0, 4'hf, 3'h1);
        check("gone", serr, 1'b1);
        acc(1'b0, 32'h48, 32'h0, 4'hf, 3'h1);
        check("base", rdat, 32'h0f0f_a5a5);
        base_jumper <= 19'h00000;
        acc(1'b0, 32'h8, 32'h0, 4'hf, 3'h1);
        check("home", rdat, 32'h0f0f_a5a5);
    endtask

    task automatic t_rereset;
        @(posedge pclk) presetn <= 1'b0;
        @(posedge pclk) presetn <= 1'b1;
        #1 check("lamp", fault_indicator, 1'b1);
        check("chan", chan_sink, 128'h0);
        acc(1'b0, 32'h0, 32'h0, 4'hf, 3'h1);
        check("clr", rdat, 32'h0);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (3000) @(posedge pclk);
        mismatches++;
        summarize;
    end

    initial begin
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        #1 check("lamp", fault_indicator, 1'b1);
        t_longwords;
        t_lanes;
        t_selftest;
        t_refuse;
        t_base;
        t_rereset;
        summarize;
    end
endmodule

/* rtl/vop_output_port.sv */
// The implementer's own choices: the APB register port and the address map.
`include "vop_params.svh"

// How it works
// - Eight 16-bit output data registers, writable and readable by software.
// - 128 bits reachable as four longwords, eight words or sixteen bytes.
// - Address bits and byte strobes choose which register lanes are touched.
// - Byte, word and longword writes by strobes at longword-aligned addresses; reads return the whole longword.
// - Short or standard space, supervisory and/or user, fixed by configuration.
// - Default configuration answers only short supervisory cycles.
// - Control/status register read/write, holds test mode and fault lamp.
// - Test mode runs while both test bits are set.
// - In test mode writes still land and read back unchanged.
// - In test mode every output driver is off.
// - Output data registers readable at any time.
// - Fault indicator comes on at every reset.
// - Only cycles matching the jumper base address are claimed.
// - Installed jumper reads zero, omitted jumper reads one.
// - Default jumpers place the board at address zero, short supervisory.
module vop_output_port #(
    parameter int unsigned ADDR_STANDARD = 0,
    parameter int unsigned ACCEPT_SUPER  = 1,
    parameter int unsigned ACCEPT_USER   = 0,
    parameter int unsigned NUM_REGS      = 8
) (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               paddr,
    input  wire logic [31:0]               pwdata,
    input  wire logic [3:0]                pstrb,
    input  wire logic [2:0]                pprot,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Base address jumpers, installed reads low
    input  wire logic [`VOP_BASE_W-1:0]    base_jumper,
    // Output channels and front panel
    output logic      [NUM_REGS*16-1:0]    chan_sink,
    output logic                           fault_indicator
);

    logic [15:0]               odr_reg [NUM_REGS];
    vop_pkg::vop_csr_t         csr_reg;
    logic [31:0]               prdata_reg;
    logic                      pready_reg;
    logic                      pslverr_reg;
    logic [NUM_REGS*16-1:0]    chan_sink_reg;
    vop_pkg::vop_decode_t      dec;
    logic                      space_ok;
    logic                      prot_ok;
    logic                      base_ok;
    logic                      access;
    logic                      wr_now;
    logic                      test_active;
    logic [31:0]               rd_next;
    logic [NUM_REGS*16-1:0]    odr_flat;
    logic [2:0]                wait_cnt;

    assign test_active = (csr_reg.test == `VOP_CSR_TEST_ON);
    assign access      = psel && penable && !pready_reg;
    assign wr_now      = psel && penable && pready_reg && pwrite && dec.claim;

    always_comb begin
        if (ADDR_STANDARD != 0) begin
            space_ok = (paddr[31:`VOP_STD_TOP+1] == '0);
        end else begin
            space_ok = (paddr[31:`VOP_SHORT_TOP+1] == '0);
        end
    end

    always_comb begin
        if (pprot[0]) begin
            prot_ok = (ACCEPT_SUPER != 0);
        end else begin
            prot_ok = (ACCEPT_USER != 0);
        end
    end

    always_comb begin
        if (ADDR_STANDARD != 0) begin
            base_ok = (paddr[`VOP_STD_TOP:`VOP_WIN_LSB] == base_jumper);
        end else begin
            base_ok = (paddr[`VOP_SHORT_TOP:`VOP_WIN_LSB]
                       == base_jumper[`VOP_SHORT_BASE_W-1:0]);
        end
    end

    always_comb begin
        dec.claim    = space_ok && prot_ok && base_ok;
        dec.lw       = paddr[3:2];
        dec.data_sel = 1'b0;
        dec.csr_sel  = 1'b0;
        if (paddr[4:0] == `VOP_OFS_CSR) begin
            dec.csr_sel = 1'b1;
        end else if (paddr[4] == 1'b0 && paddr[1:0] == 2'h0) begin
            dec.data_sel = 1'b1;
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        if (dec.data_sel) begin
            rd_next = {odr_reg[{dec.lw, 1'b1}], odr_reg[{dec.lw, 1'b0}]};
        end else if (dec.csr_sel) begin
            rd_next = {29'h0000_0000, csr_reg};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= access;
            pslverr_reg <= access && !(dec.claim
                                       && (dec.data_sel || dec.csr_sel));
            if (access && !pwrite && dec.claim) begin
                prdata_reg <= rd_next;
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi = gi + 1) begin : g_odr
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    odr_reg[gi] <= 16'h0000;
                end else if (wr_now && dec.data_sel
                             && dec.lw == 2'(gi / 2)) begin
                    if (pstrb[(gi % 2) * 2]) begin
                        odr_reg[gi][7:0] <= pwdata[(gi % 2) * 16 +: 8];
                    end
                    if (pstrb[(gi % 2) * 2 + 1]) begin
                        odr_reg[gi][15:8] <= pwdata[(gi % 2) * 16 + 8 +: 8];
                    end
                end
            end
            assign odr_flat[gi*16 +: 16] = odr_reg[gi];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            csr_reg <= `VOP_CSR_RESET;
        end else if (wr_now && dec.csr_sel && pstrb[0]) begin
            csr_reg.test  <= pwdata[`VOP_CSR_TEST_MSB:`VOP_CSR_TEST_LSB];
            csr_reg.fault <= pwdata[`VOP_CSR_FAULT_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_sink_reg <= '0;
        end else if (test_active) begin
            chan_sink_reg <= '0;
        end else begin
            chan_sink_reg <= odr_flat;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 3'h0;
        end else if (access) begin
            if (wait_cnt != 3'h7) begin
                wait_cnt <= wait_cnt + 3'h1;
            end
        end else begin
            wait_cnt <= 3'h0;
        end
    end

    assign prdata          = prdata_reg;
    assign pready          = pready_reg;
    assign pslverr         = pslverr_reg;
    assign chan_sink       = chan_sink_reg;
    assign fault_indicator = csr_reg.fault;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wait;
        psel && penable && !pready;
    endsequence

    sequence s_done;
        psel && penable && pready;
    endsequence

    sequence s_csr_write;
        psel && penable && pready && pwrite && dec.claim && dec.csr_sel
        && pstrb[0];
    endsequence

    sequence s_data_write;
        psel && penable && pready && pwrite && dec.claim && dec.data_sel;
    endsequence

    a_ack_timing: assert property (
        s_wait |=> pready ##1 !pready)
        else $error("acknowledge not given one cycle into access");

    a_unclaimed_error: assert property (
        s_wait and !dec.claim |=> pslverr)
        else $error("unmatched cycle not flagged");

    a_user_refused: assert property (
        s_wait and !pprot[0] and ACCEPT_USER == 0 |=> pslverr)
        else $error("user cycle accepted by supervisory board");

    a_word_written: assert property (
        s_done and pwrite and dec.claim and dec.data_sel and pstrb == 4'hf
        |=> {odr_reg[{$past(dec.lw), 1'b1}], odr_reg[{$past(dec.lw), 1'b0}]}
            == $past(pwdata))
        else $error("longword write not stored");

    a_lane_kept: assert property (
        s_done and pwrite and dec.data_sel and pstrb[0] == 1'b0
        |=> odr_reg[{$past(dec.lw), 1'b0}][7:0]
            == $past(odr_reg[{dec.lw, 1'b0}][7:0]))
        else $error("unstrobed byte changed");

    a_readback_data: assert property (
        s_wait and !pwrite and dec.claim and dec.data_sel
        |=> prdata == {odr_reg[{$past(dec.lw), 1'b1}],
                       odr_reg[{$past(dec.lw), 1'b0}]})
        else $error("read data differs from register");

    a_test_drivers_off: assert property (
        test_active |=> chan_sink == '0)
        else $error("driver on during test mode");

    a_outputs_follow: assert property (
        !test_active |=> chan_sink == $past(odr_flat))
        else $error("outputs do not follow data registers");

    a_test_enter: assert property (
        s_done and pwrite and dec.claim and dec.csr_sel and pstrb[0]
        and pwdata[1:0] == 2'h3 |=> test_active ##1 chan_sink == '0)
        else $error("test mode not entered");

    a_fault_clear: assert property (
        s_done and pwrite and dec.claim and dec.csr_sel and pstrb[0]
        and !pwdata[2] |=> !fault_indicator)
        else $error("fault indicator not cleared");

    a_space_refused: assert property (
        s_wait and ADDR_STANDARD == 0 and paddr[31:16] != 16'h0000
        |=> pslverr)
        else $error("cycle outside short space not refused");

    a_reset_state: assert property (
        $rose(presetn) |-> fault_indicator && chan_sink == '0 && !pready)
        else $error("outputs not at reset values after reset");

    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("acknowledge held longer than one cycle");

    a_error_with_ready: assert property (
        pslverr |-> pready)
        else $error("error flag without acknowledge");

    a_idle_read_zero: assert property (
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data driven outside acknowledge");

    a_access_bounded: assert property (
        wait_cnt <= 3'h1)
        else $error("access phase not acknowledged in time");

    a_refused_kept: assert property (
        s_done and pwrite and !dec.claim
        |=> $stable(odr_flat) && $stable(csr_reg))
        else $error("unclaimed write changed a register");

    a_base_claim: assert property (
        s_wait and ADDR_STANDARD == 0 and ACCEPT_SUPER != 0 and pprot[0]
        and paddr[31:16] == 16'h0000 and paddr[4] == 1'b0
        and paddr[15:5] == base_jumper[10:0] and paddr[1:0] == 2'h0
        |=> pready && !pslverr)
        else $error("matching base address not claimed");

    a_unaligned_refused: assert property (
        s_wait and paddr[1:0] != 2'h0 |=> pslverr)
        else $error("unaligned cycle not refused");

    a_byte_write: assert property (
        s_data_write and pstrb == 4'h4
        |=> odr_reg[{$past(dec.lw), 1'b1}][7:0] == $past(pwdata[23:16]))
        else $error("byte write not stored in its lane");

    a_test_readback: assert property (
        s_wait and test_active and !pwrite and dec.claim and dec.data_sel
        |=> prdata == {odr_reg[{$past(dec.lw), 1'b1}],
                       odr_reg[{$past(dec.lw), 1'b0}]})
        else $error("test pattern not read back");

    a_test_leave: assert property (
        s_csr_write and pwdata[1:0] != 2'h3
        |=> !test_active ##1 chan_sink == $past(odr_flat))
        else $error("test mode not left");

    a_csr_readback: assert property (
        s_wait and !pwrite and dec.claim and dec.csr_sel
        |=> prdata[2] == fault_indicator && prdata[31:3] == 29'h0000_0000)
        else $error("control/status read differs from lamp");

    a_fault_set: assert property (
        s_csr_write and pwdata[2] |=> fault_indicator)
        else $error("fault indicator not set by write");

    a_fault_steady: assert property (
        !(psel && penable && pready && pwrite) |=> $stable(fault_indicator))
        else $error("fault indicator changed without a write");

endmodule
